// >>> sfr_pkg.sv
// Purpose: Shared constants and types for the synthesizer serial host
// Assumes: 24-bit serial words, MSB first, latched by a load strobe
// Notes: Wishbone map and link timing live here
package sfr_pkg;

    // ****************************************
    // Serial word layout
    // ****************************************
    localparam int WORD_W = 24;
    localparam int BIT_CNT_W = 5;
    localparam logic [BIT_CNT_W-1:0] WORD_BITS = 5'h18;
    localparam logic [2:0] SEL_CHAN = 3'h0;
    localparam logic [2:0] SEL_PHASE = 3'h2;
    localparam logic [2:0] SEL_FUNC = 3'h3;
    localparam logic [2:0] SEL_TIMER = 3'h4;
    localparam logic [1:0] TSEL_BOOST = 2'h2;
    localparam logic [1:0] TSEL_SW3 = 2'h1;
    localparam logic [1:0] TSEL_SW12 = 2'h0;
    localparam logic [9:0] TIMER_RSVD = 10'h001;
    localparam logic [9:0] FUNC_RSVD = 10'h001;
    localparam logic [7:0] UPPER_ZERO = 8'h00;
    localparam logic [8:0] SW_MARGIN = 9'h007;
    localparam logic [8:0] TIMER_MAX = 9'h1ff;

    // ****************************************
    // Wishbone register map
    // ****************************************
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CHAN = 8'h04;
    localparam logic [7:0] A_PHASE = 8'h08;
    localparam logic [7:0] A_TIMER = 8'h0c;
    localparam logic [7:0] A_MOD = 8'h10;
    localparam logic [7:0] A_CMD = 8'h14;
    localparam logic [7:0] A_STAT = 8'h18;
    localparam int CTRL_CLAMP = 0;
    localparam int CTRL_POL = 1;
    localparam int CTRL_AUTO = 2;
    localparam int CTRL_ALIGN = 3;
    localparam int CMD_INIT = 0;
    localparam int CMD_CHAN = 1;
    localparam int CMD_PHASE = 2;
    localparam int CHAN_INT_LSB = 16;
    localparam int TMR_SW3_LSB = 9;
    localparam int TMR_SW12_LSB = 18;
    localparam int STAT_SENT_LSB = 8;
    localparam int STAT_REF_LSB = 16;
    localparam logic [31:0] CTRL_MASK = 32'h0000_000f;
    localparam logic [31:0] CHAN_MASK = 32'h01ff_0fff;
    localparam logic [31:0] PHASE_MASK = 32'h0000_0fff;
    localparam logic [31:0] TIMER_MASK = 32'h07ff_ffff;
    localparam logic [31:0] MOD_MASK = 32'h0000_0fff;
    localparam logic [31:0] CTRL_RST = 32'h0000_0005;
    localparam logic [31:0] CHAN_RST = 32'h0000_0000;
    localparam logic [31:0] PHASE_RST = 32'h0000_0000;
    localparam logic [31:0] TIMER_RST = 32'h0000_0000;
    localparam logic [31:0] MOD_RST = 32'h0000_000d;

    // ****************************************
    // Timing
    // ****************************************
    localparam int SYS_PERIOD_NS = 40;
    localparam int LINK_PERIOD_NS = 320;
    localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic sclk;
        logic sdata;
        logic sle;
    } sfr_link_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } sfr_wbreq_t;

    typedef enum logic [2:0] {
        SH_IDLE = 3'b000,
        SH_LOW = 3'b001,
        SH_HIGH = 3'b010,
        SH_LATCH = 3'b011,
        SH_END = 3'b100
    } sfr_sh_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_NEXT = 3'b001,
        ST_ALIGN = 3'b010,
        ST_LOAD = 3'b011,
        ST_SHIFT = 3'b100
    } sfr_state_t;

    typedef enum logic [1:0] {
        JOB_INIT = 2'b00,
        JOB_CHAN = 2'b01,
        JOB_PHASE = 2'b10
    } sfr_job_t;

endpackage : sfr_pkg

// >>> sfr_tick.sv
// Purpose: Enable pulse every DIV system clocks
// Assumes: DIV between 1 and 256
// Notes: Sets the serial link half period
`timescale 1ns/10ps
`default_nettype none
module sfr_tick
    import sfr_pkg::*;
#(
    parameter int DIV = LINK_HALF_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);
    localparam logic [7:0] LAST = 8'(DIV - 1);
    logic [7:0] cnt_r;
    wire wrap = (cnt_r == LAST);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 8'h00;
            tick <= 1'b0;
        end else begin
            cnt_r <= wrap ? 8'h00 : cnt_r + 8'h01;
            tick <= wrap;
        end
    end
endmodule : sfr_tick
`default_nettype wire

// >>> sfr_shift.sv
// Purpose: Shifts one 24-bit word out MSB first, then pulses the load strobe
// Assumes: start only while busy is low
// Notes: Data changes while the serial clock is low
`timescale 1ns/10ps
`default_nettype none
module sfr_shift
    import sfr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic start,
    input wire logic [WORD_W-1:0] word,
    output sfr_link_t link,
    output logic busy,
    output logic done
);
    sfr_sh_t state_r;
    logic [WORD_W-1:0] sh_r;
    logic [BIT_CNT_W-1:0] cnt_r;
    logic [BIT_CNT_W-1:0] edges_r;

    assign busy = (state_r != SH_IDLE);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= SH_IDLE;
            sh_r <= '0;
            cnt_r <= '0;
            link <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_r)
                SH_IDLE: begin
                    if (start) begin
                        sh_r <= word;
                        cnt_r <= WORD_BITS;
                        state_r <= SH_LOW;
                    end
                end
                SH_LOW: begin
                    if (tick) begin
                        link.sclk <= 1'b0;
                        link.sdata <= sh_r[WORD_W-1];
                        state_r <= SH_HIGH;
                    end
                end
                SH_HIGH: begin
                    if (tick) begin
                        link.sclk <= 1'b1;
                        sh_r <= {sh_r[WORD_W-2:0], 1'b0};
                        cnt_r <= cnt_r - 5'h01;
                        state_r <= (cnt_r == 5'h01) ? SH_LATCH : SH_LOW;
                    end
                end
                SH_LATCH: begin
                    if (tick) begin
                        link.sclk <= 1'b0;
                        link.sle <= 1'b1;
                        state_r <= SH_END;
                    end
                end
                SH_END: begin
                    if (tick) begin
                        link.sle <= 1'b0;
                        done <= 1'b1;
                        state_r <= SH_IDLE;
                    end
                end
                default: state_r <= SH_IDLE;
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edges_r <= '0;
        end else if (start && !busy) begin
            edges_r <= '0;
        end else if (link.sclk && !$past(link.sclk)) begin
            edges_r <= edges_r + 5'h01;
        end
    end

    a_word_length: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(link.sle) |-> (edges_r == WORD_BITS))
        else $error("load strobe after wrong number of clocks");
    a_strobe_clk_low: assert property (@(posedge clk) disable iff (!rst_n)
        link.sle |-> !link.sclk)
        else $error("serial clock high during load strobe");
endmodule : sfr_shift
`default_nettype wire

// >>> sfr_host.sv
// Purpose: Host that programs phase, function and fast-lock timer words
// Assumes: Reference slower than a quarter of the system clock
// Notes: Software orders word sequences through a Wishbone slave
// Summary of operation
// - Phase word carries select code 0,1,0
// - Phase write always followed by channel write
// - Channel writes spaced by whole modulus cycles
// - Paired synthesizers load in same reference cycle
// - Phase word bit 15 sent as zero
// - Function word select code 0,1,1, init only
// - Function bits 15..6 are 0x001, bit4 one
// - Timer word select code 1,0,0
// - Timer word bits 23..14 are 0x001
// - Init writes timer register three times
// - Switch timers default to boost plus seven
// - Channel word select code 0,0,0
`timescale 1ns/10ps
`default_nettype none
module sfr_host
    import sfr_pkg::*;
#(
    parameter int HALF_CYC = LINK_HALF_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic REF_IN,
    output logic SER_CLK,
    output logic SER_DATA,
    output logic SER_LE,
    output logic BUSY
);
    // ****************************************
    // Reset release
    // ****************************************
    logic rst_meta_r;
    logic rst_n;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // ****************************************
    // Wishbone slave
    // ****************************************
    sfr_wbreq_t req;
    logic [31:0] ctrl_r, chan_r, phase_r, timer_r, mod_r;
    logic [31:0] rd_data;
    sfr_state_t state_r, state_nxt;

    assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, adr: WB_ADR_I,
                   sel: WB_SEL_I, dat: WB_DAT_I};

    function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                             input logic [31:0] din,
                                             input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = din[8*i +: 8];
            end
        end
        return res;
    endfunction : wb_merge

    // Answer one cycle after the strobe, one cycle wide
    wire wb_hit = req.cyc && req.stb && !WB_ACK_O;
    wire wr_hit = wb_hit && req.we;
    wire wr_ctrl = wr_hit && (req.adr == A_CTRL);
    wire wr_chan = wr_hit && (req.adr == A_CHAN);
    wire wr_phase = wr_hit && (req.adr == A_PHASE);
    wire wr_timer = wr_hit && (req.adr == A_TIMER);
    wire wr_mod = wr_hit && (req.adr == A_MOD);
    // Orders given while busy are dropped so a sequence never tears
    wire cmd_go = wr_hit && (req.adr == A_CMD) && req.sel[0] && (state_r == ST_IDLE)
                  && (req.dat[2:0] != 3'h0);

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RST;
            chan_r <= CHAN_RST;
            phase_r <= PHASE_RST;
            timer_r <= TIMER_RST;
            mod_r <= MOD_RST;
        end else begin
            if (wr_ctrl) ctrl_r <= wb_merge(ctrl_r, req.dat, req.sel) & CTRL_MASK;
            if (wr_chan) chan_r <= wb_merge(chan_r, req.dat, req.sel) & CHAN_MASK;
            if (wr_phase) phase_r <= wb_merge(phase_r, req.dat, req.sel) & PHASE_MASK;
            if (wr_timer) timer_r <= wb_merge(timer_r, req.dat, req.sel) & TIMER_MASK;
            if (wr_mod) mod_r <= wb_merge(mod_r, req.dat, req.sel) & MOD_MASK;
        end
    end

    // ****************************************
    // Reference phase counter
    // ****************************************
    logic ref_meta_r, ref_sync_r, ref_old_r;
    logic [11:0] ref_cnt_r;
    logic ref_wrap_r;
    wire [11:0] mod_val = mod_r[11:0];
    wire ref_rise = ref_sync_r && !ref_old_r;
    wire ref_last = (mod_val == 12'h000) || (ref_cnt_r >= mod_val - 12'h001);

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ref_meta_r <= 1'b0;
            ref_sync_r <= 1'b0;
            ref_old_r <= 1'b0;
        end else begin
            ref_meta_r <= REF_IN;
            ref_sync_r <= ref_meta_r;
            ref_old_r <= ref_sync_r;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ref_cnt_r <= 12'h000;
            ref_wrap_r <= 1'b0;
        end else begin
            ref_wrap_r <= ref_rise && ref_last;
            if (ref_rise) ref_cnt_r <= ref_last ? 12'h000 : ref_cnt_r + 12'h001;
        end
    end

    // ****************************************
    // Serial word builder
    // ****************************************
    sfr_job_t job_r;
    logic [1:0] step_r, last_r;
    logic [7:0] sent_r;
    logic [WORD_W-1:0] word_sel;

    wire [8:0] t_boost = timer_r[8:0];
    wire [9:0] boost_plus = {1'b0, t_boost} + {1'b0, SW_MARGIN};
    wire [8:0] sw_auto = boost_plus[9] ? TIMER_MAX : boost_plus[8:0];
    wire auto_sw = ctrl_r[CTRL_AUTO];
    wire [8:0] t_sw3 = auto_sw ? sw_auto : timer_r[TMR_SW3_LSB +: 9];
    wire [8:0] t_sw12 = auto_sw ? sw_auto : timer_r[TMR_SW12_LSB +: 9];
    // Seed beyond the modulus is out of range for the modulator
    wire [11:0] phase_eff = (phase_r[11:0] > mod_val) ? mod_val : phase_r[11:0];

    // Clamp bit is sent as written; one releases the pump outputs
    wire [WORD_W-1:0] w_func = {UPPER_ZERO, FUNC_RSVD, ctrl_r[CTRL_CLAMP], 1'b1,
                                ctrl_r[CTRL_POL], SEL_FUNC};
    wire [WORD_W-1:0] w_phase = {UPPER_ZERO, 1'b0, phase_eff, SEL_PHASE};
    wire [WORD_W-1:0] w_chan = {chan_r[CHAN_INT_LSB +: 9], chan_r[11:0], SEL_CHAN};
    wire [WORD_W-1:0] w_boost = {TIMER_RSVD, t_boost, TSEL_BOOST, SEL_TIMER};
    wire [WORD_W-1:0] w_sw3 = {TIMER_RSVD, t_sw3, TSEL_SW3, SEL_TIMER};
    wire [WORD_W-1:0] w_sw12 = {TIMER_RSVD, t_sw12, TSEL_SW12, SEL_TIMER};

    // Init sends function word, then one timer word per counter
    always_comb begin
        word_sel = w_chan;
        case (job_r)
            JOB_INIT: begin
                case (step_r)
                    2'h0: word_sel = w_func;
                    2'h1: word_sel = w_boost;
                    2'h2: word_sel = w_sw3;
                    default: word_sel = w_sw12;
                endcase
            end
            JOB_PHASE: word_sel = (step_r == 2'h0) ? w_phase : w_chan;
            default: word_sel = w_chan;
        endcase
    end

    wire is_chan = (word_sel[2:0] == SEL_CHAN);
    wire align_en = ctrl_r[CTRL_ALIGN];

    // ****************************************
    // Sequencer
    // ****************************************
    logic tick;
    logic sh_start, sh_busy, sh_done;
    sfr_link_t link;

    assign sh_start = (state_r == ST_LOAD);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (cmd_go) state_nxt = ST_NEXT;
            // Aligning to the wrap keeps every channel load a whole number of
            // modulus cycles after the last; two hosts on one reference land
            // in the same cycle
            ST_NEXT: state_nxt = (is_chan && align_en) ? ST_ALIGN : ST_LOAD;
            ST_ALIGN: if (ref_wrap_r) state_nxt = ST_LOAD;
            ST_LOAD: state_nxt = ST_SHIFT;
            ST_SHIFT: if (sh_done) state_nxt = (step_r == last_r) ? ST_IDLE : ST_NEXT;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            job_r <= JOB_CHAN;
            step_r <= 2'h0;
            last_r <= 2'h0;
            BUSY <= 1'b0;
        end else begin
            state_r <= state_nxt;
            BUSY <= (state_nxt != ST_IDLE);
            if (cmd_go) begin
                step_r <= 2'h0;
                if (req.dat[CMD_INIT]) begin
                    job_r <= JOB_INIT;
                    last_r <= 2'h3;
                end else if (req.dat[CMD_PHASE]) begin
                    job_r <= JOB_PHASE;
                    last_r <= 2'h1;
                end else begin
                    job_r <= JOB_CHAN;
                    last_r <= 2'h0;
                end
            end else if (state_r == ST_SHIFT && sh_done && step_r != last_r) begin
                step_r <= step_r + 2'h1;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            sent_r <= 8'h00;
        end else if (sh_done) begin
            sent_r <= sent_r + 8'h01;
        end
    end

    sfr_tick #(.DIV(HALF_CYC)) u_tick (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .tick(tick)
    );

    sfr_shift u_shift (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .tick(tick),
        .start(sh_start),
        .word(word_sel),
        .link(link),
        .busy(sh_busy),
        .done(sh_done)
    );

    assign SER_CLK = link.sclk;
    assign SER_DATA = link.sdata;
    assign SER_LE = link.sle;

    // ****************************************
    // Read back
    // ****************************************
    wire [31:0] stat_word = {4'h0, ref_cnt_r, sent_r, 7'h00, BUSY};

    always_comb begin
        case (req.adr)
            A_CTRL: rd_data = ctrl_r;
            A_CHAN: rd_data = chan_r;
            A_PHASE: rd_data = phase_r;
            A_TIMER: rd_data = timer_r;
            A_MOD: rd_data = mod_r;
            A_STAT: rd_data = stat_word;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= wb_hit;
            WB_DAT_O <= (wb_hit && !req.we) ? rd_data : 32'h0000_0000;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    logic [2:0] init_tmr_r;

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            init_tmr_r <= 3'h0;
        end else if (cmd_go) begin
            init_tmr_r <= 3'h0;
        end else if (sh_start && word_sel[2:0] == SEL_TIMER) begin
            init_tmr_r <= init_tmr_r + 3'h1;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!rst_n);

    a_init_timers: assert property (
        (state_r == ST_SHIFT && sh_done && job_r == JOB_INIT && step_r == last_r)
        |=> (init_tmr_r == 3'h3))
        else $error("init did not send three timer words");
    a_phase_then_chan: assert property (
        (state_r == ST_SHIFT && sh_done && job_r == JOB_PHASE && step_r == 2'h0)
        |=> (state_r == ST_NEXT) ##1 (word_sel[2:0] == SEL_CHAN))
        else $error("phase word not followed by channel word");
    a_phase_reserved: assert property (
        (sh_start && word_sel[2:0] == SEL_PHASE) |-> (word_sel[15] == 1'b0))
        else $error("phase word reserved bit set");
    a_func_reserved: assert property (
        (sh_start && word_sel[2:0] == SEL_FUNC)
        |-> (word_sel[15:6] == FUNC_RSVD && word_sel[4]))
        else $error("function word reserved field wrong");
    a_timer_reserved: assert property (
        (sh_start && word_sel[2:0] == SEL_TIMER) |-> (word_sel[23:14] == TIMER_RSVD))
        else $error("timer word reserved field wrong");
    a_sw_auto: assert property (
        (sh_start && auto_sw && word_sel[4:0] == {TSEL_SW3, SEL_TIMER}
         && t_boost < 9'h1f0) |-> (word_sel[13:5] == t_boost + SW_MARGIN))
        else $error("switch timer not boost plus seven");
    a_align_wrap: assert property (
        (state_r == ST_LOAD && $past(state_r) == ST_ALIGN) |-> $past(ref_wrap_r))
        else $error("channel word started off the modulus wrap");
    a_phase_clamp: assert property (
        (sh_start && word_sel[2:0] == SEL_PHASE) |-> (word_sel[14:3] <= mod_val))
        else $error("phase seed above modulus");
    a_start_idle: assert property (
        sh_start |-> !sh_busy)
        else $error("word started while shifter busy");
    a_ack_single: assert property (
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
endmodule : sfr_host
`default_nettype wire

// >>> sfr_dev_model.sv
// Purpose: Behavioural synthesizer register model
// Assumes: Link pins sampled on the system clock
// Notes: No reset, as on the part; latches on the load strobe
`timescale 1ns/10ps
`default_nettype none
module sfr_dev_model (
    input wire logic clk,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic le,
    input wire logic ref_clk,
    output logic [23:0] fw,
    output logic [23:0] pw,
    output logic [23:0] cw,
    output logic [23:0] tw,
    output logic [8:0] bt,
    output logic [8:0] s3,
    output logic [8:0] s12,
    output logic [11:0] ph,
    output logic [7:0] nw,
    output logic [1:0] sw,
    output logic [6:0] pump
);
    logic [23:0] sr;
    logic [11:0] ph_sh;
    logic ck_q = 1'b0;
    logic le_q = 1'b0;
    logic rf_q = 1'b0;
    logic [1:0] q4 = 2'h0;
    logic [8:0] bt_c = 9'h000;
    logic [8:0] s3_c = 9'h000;
    logic [8:0] s12_c = 9'h000;
    // Counters advance on every fourth detector edge
    wire qtick = ref_clk && !rf_q && (q4 == 2'h3);
    // Zero count leaves the switch open at once
    assign sw = {s12_c != 9'h000, s3_c != 9'h000};
    initial nw = 8'h00;
    initial pump = 7'h01;
    always @(posedge clk) begin
        ck_q <= sclk;
        le_q <= le;
        rf_q <= ref_clk;
        if (ref_clk && !rf_q) q4 <= q4 + 2'h1;
        if (qtick) begin
            if (bt_c != 9'h000) bt_c <= bt_c - 9'h001;
            if (s3_c != 9'h000) s3_c <= s3_c - 9'h001;
            if (s12_c != 9'h000) s12_c <= s12_c - 9'h001;
            // Six halvings bring 64x back to 1x
            if (bt_c == 9'h000 && pump != 7'h01) pump <= pump >> 1;
        end
        if (sclk && !ck_q) sr <= {sr[22:0], sdata};
        if (le && !le_q) begin
            nw <= nw + 8'h01;
            case (sr[2:0])
                3'h2: begin
                    pw <= sr;
                    ph_sh <= sr[14:3];
                end
                3'h3: fw <= sr;
                3'h4: begin
                    tw <= sr;
                    if (sr[4:3] == 2'h2) bt <= sr[13:5];
                    if (sr[4:3] == 2'h1) s3 <= sr[13:5];
                    if (sr[4:3] == 2'h0) s12 <= sr[13:5];
                end
                3'h0: begin
                    cw <= sr;
                    ph <= ph_sh;
                    // Reload restarts counters still running
                    bt_c <= bt;
                    s3_c <= s3;
                    s12_c <= s12;
                    q4 <= 2'h0;
                    pump <= 7'h40;
                end
                default: ;
            endcase
        end
    end
endmodule : sfr_dev_model
`default_nettype wire

// >>> tb_sfr_host.sv
// Purpose: Self-checking bench for the serial host
// Assumes: Device model decodes every word
// Notes: Xorshift values from a fixed seed
`timescale 1ns/10ps
`default_nettype none
module tb_sfr_host;
    import sfr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ref_in = 1'b0;
    sfr_wbreq_t rq = '0;
    logic [31:0] seed = 32'd54265;
    logic [31:0] rd, v, m, p, c, e;
    logic [8:0] b, s3, s12, mb, m3, m12;
    logic [31:0] drd;
    logic ack, sck, sd, le, busy;
    logic [23:0] fw, pw, cw, tw;
    logic [11:0] pa;
    logic [7:0] nw, n0;
    logic [1:0] sw;
    logic [6:0] pump;
    int err_count = 0;
    int n_tests = 0;
    initial forever #20 clk = ~clk;
    initial forever #160 ref_in = ~ref_in;
    sfr_host #(.HALF_CYC(4)) i_dut (.SYS_CLK(clk), .RST_N(rst_n), .WB_CYC_I(rq.cyc),
        .WB_STB_I(rq.stb), .WB_WE_I(rq.we), .WB_ADR_I(rq.adr), .WB_SEL_I(rq.sel),
        .WB_DAT_I(rq.dat), .WB_DAT_O(drd), .WB_ACK_O(ack), .REF_IN(ref_in),
        .SER_CLK(sck), .SER_DATA(sd), .SER_LE(le), .BUSY(busy));
    sfr_dev_model i_dev (.clk(clk), .sclk(sck), .sdata(sd), .le(le), .fw(fw), .pw(pw),
        .cw(cw), .tw(tw), .bt(mb), .s3(m3), .s12(m12), .ph(pa), .nw(nw), .ref_clk(ref_in),
        .sw(sw), .pump(pump));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [8:0] sat7(input logic [8:0] x);
        return (x > 9'h1f8) ? 9'h1ff : x + 9'h007;
    endfunction : sat7
    task automatic conclude();
        $display("Counts: %0d checks, %0d bad", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        rq <= '{1'b1, 1'b1, w, a, 4'hf, d};
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (ack !== 1'b1 && i < 50);
        rd = drd;
        rq <= '0;
        if (ack !== 1'b1) begin
            err_count++;
            conclude();
        end
        @(posedge clk);
    endtask : wb
    task automatic idle();
        int i;
        repeat (2) @(posedge clk);
        for (i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge clk);
        if (i >= 5000) begin
            err_count++;
            conclude();
        end
    endtask : idle
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        wb(1'b0, A_CTRL, 32'h0);
        check(rd, CTRL_RST);
        wb(1'b0, A_MOD, 32'h0);
        check(rd, MOD_RST);
        wb(1'b0, 8'h1c, 32'h0);
        check(rd, 32'h0);
        $display("Reset values done");
        // Last pass saturates the automatic switch timers
        for (int k = 0; k < 5; k++) begin
            v = rnd();
            b = (k == 4) ? 9'h1fe : v[8:0];
            s3 = v[17:9];
            s12 = v[26:18];
            m = (k == 4) ? 32'h7 : (k == 3) ? 32'h6 : k;
            wb(1'b1, A_CTRL, m);
            wb(1'b1, A_TIMER, {5'h00, s12, s3, b});
            wb(1'b0, A_TIMER, 32'h0);
            check(rd, {5'h00, s12, s3, b});
            n0 = nw;
            wb(1'b1, A_CMD, 32'h1);
            idle();
            check(fw, {8'h00, 10'h001, m[0], 1'b1, m[1], 3'b011});
            check(mb, b);
            check(m3, m[2] ? sat7(b) : s3);
            check(m12, m[2] ? sat7(b) : s12);
            check(tw[23:14], 10'h001);
            check(nw - n0, 4);
        end
        $display("Init sequences done");
        for (int k = 0; k < 3; k++) begin
            v = rnd();
            m = 32'd13 + v[10:0];
            p = (k == 0) ? m + 5 : (k == 1) ? m : {20'h0, v[23:12]};
            c = rnd() & CHAN_MASK;
            e = (p > m) ? m : p;
            wb(1'b1, A_MOD, m);
            wb(1'b1, A_PHASE, p);
            wb(1'b1, A_CHAN, c);
            n0 = nw;
            wb(1'b1, A_CMD, 32'h4);
            idle();
            check(pw, {8'h00, 1'b0, e[11:0], 3'b010});
            check(pa, e[11:0]);
            check(cw, {c[24:16], c[11:0], 3'b000});
            check(nw - n0, 2);
            check({sw, pump}, {2'b11, 7'h40});
        end
        $display("Phase sequences done");
        // Short modulus keeps the wait for the wrap small
        wb(1'b1, A_MOD, 32'd13);
        wb(1'b1, A_CTRL, 32'hf);
        c = rnd() & CHAN_MASK;
        wb(1'b1, A_CHAN, c);
        n0 = nw;
        wb(1'b1, A_CMD, 32'h2);
        wb(1'b1, A_CMD, 32'h1);
        check(busy, 1'b1);
        idle();
        check(cw, {c[24:16], c[11:0], 3'b000});
        check(nw - n0, 1);
        check(pa, e[11:0]);
        wb(1'b0, A_STAT, 32'h0);
        check(rd & 32'h0000_ffff, {16'h0000, nw, 8'h00});
        $display("Channel and busy refusal done");
        conclude();
    end
endmodule : tb_sfr_host
`default_nettype wire
